// >>> bench/serial_word_source.sv
/* serial port word source for one transmit channel.
   assumes words are taken on a clock edge with valid and ready high. */
`default_nettype none
module serial_word_source #(
   parameter logic [15:0] BASE = 16'hA000
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic port_en_i,
   input wire logic ready_i,
   output logic [15:0] word_o,
   output logic valid_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] n_reg;
   // counts words taken; the offered word stays until taken
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         n_reg <= 16'h0000;
      end else if (valid_o && ready_i) begin
         n_reg <= n_reg + 16'h0001;
      end
   end
   // no offer while the port is off; a released line shows the
   // inverse of the last word so a stale copy cannot pass
   assign valid_o = port_en_i && !rst_i;
   assign word_o = valid_o ? BASE + n_reg : ~(BASE + n_reg - 16'h0001);
endmodule // serial_word_source
`default_nettype wire

// >>> bench/tx_channel_control_props.sv
/* port assertions for tx_channel_control.
   assumes one clock domain; attached by the bind at the foot. */
`default_nettype none
module tx_channel_control_props
   import tx_chan_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // control port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // channel side
   input wire logic [1:0] word_ready_o,
   input wire logic [1:0] input_sample_tick_i,
   input wire logic [1:0] filter_sample_tick_i,
   input wire logic [1:0] fir_in_valid_o,
   input wire logic [1:0] stage2_valid_o,
   input wire logic [1:0] chan_active_o,
   input wire logic [1:0] data_clear_o,
   input wire logic [1:0][6:0] data_clear_addr_o,
   input wire logic bypass_o,
   // analogue side
   input wire logic [1:0] analog_en_o,
   input wire logic [1:0][5:0] gain_o,
   input wire logic [1:0] mute_o,
   input wire logic [1:0] mid_rail_o,
   input wire logic [1:0] out_hiz_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // all checks share the system clock and its reset
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   a_ready_in_run: assert property (
      word_ready_o[0] |-> chan_active_o[0]) else $error("ready idle");
   a_clear_span: assert property (
      $rose(data_clear_o[0]) |-> (data_clear_o[0] throughout ##127 1'b1)
      ##1 !data_clear_o[0]) else $error("clear length");
   a_clear_start: assert property (
      $rose(data_clear_o[0]) |-> data_clear_addr_o[0] == 7'h00
      && !chan_active_o[0]) else $error("clear start");
   a_fir_follows: assert property (
      input_sample_tick_i[0] && word_ready_o[0] |=> fir_in_valid_o[0])
      else $error("no sample");
   a_fir_cause: assert property (
      fir_in_valid_o[0] |-> $past(input_sample_tick_i[0]))
      else $error("stray sample");
   a_stage2_cause: assert property (
      stage2_valid_o[0] && !bypass_o |-> $past(filter_sample_tick_i[0]))
      else $error("stray selector output");
   a_mute_code: assert property (
      mute_o == {gain_o[1] == MUTE_CODE, gain_o[0] == MUTE_CODE})
      else $error("mute code");
   a_pin_mode: assert property (
      $onehot({analog_en_o[0], mid_rail_o[0], out_hiz_o[0]})
      && $onehot({analog_en_o[1], mid_rail_o[1], out_hiz_o[1]}))
      else $error("pin mode");
   a_rd_other: assert property (
      reg_rd_i && reg_addr_i != ADDR_STAT |=> reg_rdata_o == 8'h00)
      else $error("read of write-only");
   a_rd_reserved: assert property (
      reg_rd_i |=> !reg_rdata_o[7] && !reg_rdata_o[3])
      else $error("reserved bit set");
endmodule // tx_channel_control_props
bind tx_channel_control tx_channel_control_props u_props (
   .clk_sys_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .word_ready_o,
   .input_sample_tick_i, .filter_sample_tick_i, .fir_in_valid_o,
   .stage2_valid_o, .chan_active_o, .data_clear_o, .data_clear_addr_o,
   .bypass_o, .analog_en_o, .gain_o, .mute_o, .mid_rail_o, .out_hiz_o);
`default_nettype wire

// >>> bench/tx_channel_control_tb.sv
/* self-checking bench for tx_channel_control.
   assumes inputs change at the falling edge of a 100 MHz clock. */
`default_nettype none
module tx_channel_control_tb
   import tx_chan_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] a; logic [15:0] d; logic [12:0] r; logic [19:0] g;
   } row_t;
   typedef struct packed {
      logic [4:0] s; logic [37:0] acc; logic [15:0] q; logic v;
   } sel_t;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic tx_port_en_i = 1'b0, bypass_o;
   logic [7:0] reg_addr_i = 8'h00, reg_rdata_o, tap_count_o;
   logic [15:0] reg_wdata_i = 16'h0000;
   wire logic [1:0][15:0] word_i;
   wire logic [1:0] word_valid_i;
   logic [1:0] input_sample_tick_i = 2'b00, filter_sample_tick_i = 2'b00;
   logic [1:0][37:0] acc_i = '0;
   logic [1:0][6:0] coef_rd_addr_i = '0, data_clear_addr_o;
   logic [1:0][15:0] fir_in_o, coef_o, stage2_o;
   logic [1:0][5:0] gain_o;
   logic [1:0] word_ready_o, fir_in_valid_o, stage2_valid_o, chan_active_o;
   logic [1:0] data_clear_o, analog_en_o, mute_o, mid_rail_o, out_hiz_o;
   logic [3:0] upsample1_o;
   int n_fail = 0, check_count = 0, n;
   row_t rows[9] = '{
      '{ADDR_RATE, 16'h0001, 13'h0300, 20'h00003},
      '{ADDR_RATE, 16'h07ED, 13'h0AFB, 20'h00003},
      '{ADDR_RATE, 16'h0040, 13'h1010, 20'h00003},
      '{ADDR_GAIN, 16'h602A, 13'h1010, 20'h20AA9},
      '{ADDR_CTRL, 16'h0202, 13'h1010, 20'hE0AA0},
      '{ADDR_GAIN, 16'h0015, 13'h1010, 20'hC0540},
      '{8'h33, 16'hFFFF, 13'h1010, 20'hC0540},
      '{ADDR_CTRL, 16'h0000, 13'h1010, 20'h00543},
      '{ADDR_GAIN, 16'h0040, 13'h1010, 20'h00006}};
   sel_t sels[8] = '{
      '{5'd0, 38'h00_0040_0000, 16'h0001, 1'b0},
      '{5'd0, 38'h00_0060_0000, 16'h0002, 1'b0},
      '{5'd0, 38'h00_0020_0000, 16'h0000, 1'b0},
      '{5'd0, 38'h00_00A0_0000, 16'h0002, 1'b0},
      '{5'd0, 38'h1F_FFFF_FFFF, 16'h7FFF, 1'b1},
      '{5'd1, 38'h10_0000_0000, 16'h7FFF, 1'b1},
      '{5'd1, 38'h20_0000_0000, 16'h8000, 1'b1},
      '{5'd22, 38'h3F_FFFF_FFFE, 16'hFFFE, 1'b0}};
   // ----------------------------------------------------------------
   // design, serial word sources and clock
   // ----------------------------------------------------------------
   tx_channel_control u_tx_channel_control (.clk_sys_i, .rst_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .tx_port_en_i, .word_i, .word_valid_i, .word_ready_o,
      .input_sample_tick_i, .filter_sample_tick_i, .acc_i, .coef_rd_addr_i,
      .fir_in_o, .fir_in_valid_o, .coef_o, .stage2_o, .stage2_valid_o,
      .chan_active_o, .data_clear_o, .data_clear_addr_o, .upsample1_o,
      .tap_count_o, .bypass_o, .analog_en_o, .gain_o, .mute_o, .mid_rail_o,
      .out_hiz_o);
   serial_word_source #(.BASE(16'hA000)) u_serial_word_source (.clk_sys_i,
      .rst_i, .port_en_i(tx_port_en_i), .ready_i(word_ready_o[0]),
      .word_o(word_i[0]), .valid_o(word_valid_i[0]));
   serial_word_source #(.BASE(16'hB000)) u_serial_word_source_b (.clk_sys_i,
      .rst_i, .port_en_i(tx_port_en_i), .ready_i(word_ready_o[1]),
      .word_o(word_i[1]), .valid_o(word_valid_i[1]));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // a write with last low keeps the strobe up for streaming
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
                     input logic last);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      if (last) begin
         @(negedge clk_sys_i);
         reg_wr_i = 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_i = 1'b0;
      @(negedge clk_sys_i);
      chk(reg_rdata_o, e);
   endtask
   task automatic pulse();
      @(negedge clk_sys_i);
      input_sample_tick_i[0] = 1'b1;
      @(negedge clk_sys_i);
      input_sample_tick_i[0] = 1'b0;
   endtask
   // one consuming tick, then time for the buffer to refill
   task automatic tick(input logic [15:0] e);
      pulse();
      chk({fir_in_valid_o[0], fir_in_o[0]}, {1'b1, e});
      repeat (4) @(negedge clk_sys_i);
   endtask
   task automatic final_report();
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      #100000;
      n_fail++;
      final_report();
   end
   initial begin
      repeat (3) @(negedge clk_sys_i);
      rst_i = 1'b0;
      rd(ADDR_STAT, STAT_RST);
      rd(ADDR_CTRL, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, 1'b1);
         @(negedge clk_sys_i);
         chk({upsample1_o, tap_count_o, bypass_o}, rows[i].r);
         chk({analog_en_o, gain_o, mute_o, mid_rail_o, out_hiz_o},
             rows[i].g);
      end
      // shared pointer reset before each bank, words streamed back to back
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_PTR, 16'h0000, 1'b1);
         for (int i = 0; i < 8; i++) begin
            wr(ADDR_COEF0 + 8'(b), 16'(16'hC000 + 16'h1000 * b + i),
               i == 7);
         end
      end
      wr(ADDR_CTRL, 16'h0100, 1'b1);
      for (int i = 0; i < 4; i++) begin
         coef_rd_addr_i = {7'(i), 7'(i)};
         repeat (2) @(negedge clk_sys_i);
         chk(coef_o, {16'(16'hD000 + i), 16'(16'hC000 + i)});
      end
      // analogue on before digital, all other settings already made
      wr(ADDR_CTRL, 16'h0002, 1'b1);
      wr(ADDR_CTRL, 16'h0006, 1'b1);
      rd(ADDR_STAT, 8'h10);
      tick(16'h0000);
      tx_port_en_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      tick(16'hA000);
      tick(16'hA001);
      tx_port_en_i = 1'b0;
      tick(16'hA002);
      tick(16'hA003);
      tick(16'hA003);
      rd(ADDR_STAT, 8'h12);
      rd(ADDR_STAT, 8'h10);
      // disable with two words buffered, then drain and clear
      tx_port_en_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      wr(ADDR_CTRL, 16'h0002, 1'b1);
      @(negedge clk_sys_i);
      chk(word_ready_o[0], 1'b0);
      tick(16'hA004);
      tick(16'hA005);
      pulse();
      n = 0;
      for (int i = 0; i < 300; i++) begin
         if (data_clear_o[0] === 1'b1) n++;
         @(negedge clk_sys_i);
      end
      chk(n, 128);
      rd(ADDR_STAT, 8'h13);
      // selector cases, overflow flag read back after each
      foreach (sels[i]) begin
         wr(ADDR_CTRL, {2{sels[i].s, 3'b110}}, 1'b1);
         @(negedge clk_sys_i);
         acc_i = {2{sels[i].acc}};
         filter_sample_tick_i = 2'b11;
         @(negedge clk_sys_i);
         filter_sample_tick_i = 2'b00;
         chk({stage2_valid_o[0], stage2_o[0]}, {1'b1, sels[i].q});
         chk({stage2_valid_o[1], stage2_o[1]}, {1'b1, sels[i].q});
         rd(ADDR_STAT, {1'b0, sels[i].v, 3'b000, sels[i].v, 2'b00});
      end
      final_report();
   end
endmodule // tx_channel_control_tb
`default_nettype wire

// >>> core/tx_bit_selector.sv
/*
 * Bit selector: picks a 16-bit field out of the filter accumulator,
 * rounds the dropped low bits half-to-even and saturates.
 * Purely combinational; the caller registers the result.
 */
`default_nettype none
module tx_bit_selector
   import tx_chan_pkg::*;
#(
   parameter int AW = ACC_W,
   parameter int OW = SAMPLE_W
) (
   // accumulator and field select (MAXD - drop_i low bits dropped)
   input wire logic [AW-1:0] acc_i,
   input wire logic [4:0] drop_i,
   // selected sample
   output logic [OW-1:0] sample_o,
   output logic sat_o
);
   localparam int MAXD = AW - OW;
   localparam logic signed [AW:0] POS = (AW+1)'((1 << (OW-1)) - 1);
   localparam logic signed [AW:0] NEG = -(AW+1)'(1 << (OW-1));
   if (MAXD < 1 || MAXD > 31) begin : g_chk
      $error("bit selector widths unsupported");
   end
   // out-of-range drop counts are clamped to the largest legal one
   always_comb begin
      int n;
      logic [AW-1:0] mask, rem, half;
      logic signed [AW:0] q;
      logic up;
      n = MAXD - ((int'(drop_i) > MAXD) ? MAXD : int'(drop_i));
      mask = (AW'(1) << n) - AW'(1);
      rem = acc_i & mask;
      half = (n == 0) ? '0 : (AW'(1) << (n - 1));
      q = $signed({acc_i[AW-1], acc_i}) >>> n;
      // ties go to the even neighbour to avoid a dc bias
      up = (n != 0) && ((rem > half) || ((rem == half) && q[0]));
      q = q + (AW+1)'(up);
      sat_o = (q > POS) || (q < NEG);
      if (q > POS) begin
         sample_o = POS[OW-1:0];
      end else if (q < NEG) begin
         sample_o = NEG[OW-1:0];
      end else begin
         sample_o = q[OW-1:0];
      end
   end
endmodule // tx_bit_selector
`default_nettype wire

// >>> core/tx_chan_pkg.sv
/*
 * Shared constants and types for the transmit channel control block:
 * control-port offsets, field positions, reset values and timing counts.
 * Assumes a host on the same system clock that drives the control port.
 */
`default_nettype none
package tx_chan_pkg;
   // ----------------------------------------------------------------
   // control-port offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RATE = 8'h31;
   localparam logic [7:0] ADDR_CTRL = 8'h34;
   localparam logic [7:0] ADDR_GAIN = 8'h35;
   localparam logic [7:0] ADDR_COEF0 = 8'h36;
   localparam logic [7:0] ADDR_COEF1 = 8'h37;
   localparam logic [7:0] ADDR_PTR = 8'h38;
   localparam logic [7:0] ADDR_STAT = 8'h39;
   // ----------------------------------------------------------------
   // field positions (per-channel fields: A at base 0, B at base stride; rate fields once)
   // ----------------------------------------------------------------
   localparam int CTRL_STRIDE = 8;
   localparam int COEF_SEL_B = 0;
   localparam int ANA_EN_B = 1;
   localparam int DIG_EN_B = 2;
   localparam int BITSEL_LSB = 3;
   localparam int GAIN_STRIDE = 8;
   localparam int GAIN_LSB = 0;
   localparam int CLAMP_B = 6;
   localparam int L1_LSB = 0;
   localparam int LEN_LSB = 3;
   localparam int BYPASS_B = 10;
   localparam int STAT_STRIDE = 4;
   localparam int IDLE_B = 0;
   localparam int UNDER_B = 1;
   localparam int OVF_B = 2;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] GAIN_RST = 16'h0000;
   localparam logic [15:0] RATE_RST = 16'h0000;
   localparam logic [6:0] PTR_RST = 7'h00;
   localparam logic [7:0] STAT_RST = 8'h11;
   localparam logic [3:0] L1_RST = 4'h8;
   localparam logic [7:0] TAPS_RST = 8'h80;
   localparam logic [5:0] MUTE_CODE = 6'h20;
   // ----------------------------------------------------------------
   // sizes and timing
   // ----------------------------------------------------------------
   localparam int ACC_W = 38;
   localparam int SAMPLE_W = 16;
   localparam int COEF_DEPTH = 128;
   localparam int CLEAR_CYCLES = 128;
   localparam int BUF_DEPTH = 2;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN, ST_CLEAR}
      chan_state_t;
endpackage
`default_nettype wire

// >>> core/tx_channel_control.sv
/*
 * Transmit channel control for channels A (index 0) and B (index 1):
 * control-port registers, enable/drain/clear sequencing, sample feed
 * with default and repeated data, bit selection, gain and clamp codes,
 * coefficient banks and status flags.
 * Assumes the serial port, filter datapath and control port run on
 * clk_sys_i; tick and accumulator strobes are single-cycle pulses.
 */
`default_nettype none
module tx_channel_control
   import tx_chan_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,

   // control port
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,

   // serial port words, per channel
   input wire logic tx_port_en_i,
   input wire logic [1:0][15:0] word_i,
   input wire logic [1:0] word_valid_i,
   output logic [1:0] word_ready_o,

   // filter side, per channel
   input wire logic [1:0] input_sample_tick_i,
   input wire logic [1:0] filter_sample_tick_i,
   input wire logic [1:0][ACC_W-1:0] acc_i,
   input wire logic [1:0][6:0] coef_rd_addr_i,
   output logic [1:0][15:0] fir_in_o,
   output logic [1:0] fir_in_valid_o,
   output logic [1:0][15:0] coef_o,
   output logic [1:0][15:0] stage2_o,
   output logic [1:0] stage2_valid_o,
   output logic [1:0] chan_active_o,
   output logic [1:0] data_clear_o,
   output logic [1:0][6:0] data_clear_addr_o,

   // rate settings
   output logic [3:0] upsample1_o,
   output logic [7:0] tap_count_o,
   output logic bypass_o,

   // analogue controls, per channel
   output logic [1:0] analog_en_o,
   output logic [1:0][5:0] gain_o,
   output logic [1:0] mute_o,
   output logic [1:0] mid_rail_o,
   output logic [1:0] out_hiz_o
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [15:0] ctrl_reg, gain_reg;
   logic [6:0] ptr_reg;
   logic [15:0] coef_mem [2][COEF_DEPTH];
   logic [7:0] stat_vec;

   logic stat_rd;
   logic wr_coef;
   // only a status read has a side effect: it clears sticky flags
   assign stat_rd = reg_rd_i && (reg_addr_i == ADDR_STAT);
   assign wr_coef = reg_wr_i &&
      ((reg_addr_i == ADDR_COEF0) || (reg_addr_i == ADDR_COEF1));

   // write-only control, gain and rate registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RST;
         gain_reg <= GAIN_RST;
         upsample1_o <= L1_RST;
         tap_count_o <= TAPS_RST;
         bypass_o <= RATE_RST[BYPASS_B];
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_CTRL: ctrl_reg <= reg_wdata_i;
            ADDR_GAIN: gain_reg <= reg_wdata_i;
            ADDR_RATE: begin
               // zero codes stand for the largest factor and length
               upsample1_o <= (reg_wdata_i[L1_LSB +: 3] == 3'h0) ?
                  4'h8 : {1'b0, reg_wdata_i[L1_LSB +: 3]};
               tap_count_o <= (reg_wdata_i[LEN_LSB +: 7] == 7'h00) ?
                  8'h80 : {1'b0, reg_wdata_i[LEN_LSB +: 7]};
               bypass_o <= reg_wdata_i[BYPASS_B];
            end
            // writes to unmapped offsets change nothing
            default: ;
         endcase
      end
   end

   // shared coefficient pointer; wraps after the last word
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ptr_reg <= PTR_RST;
      end else if (reg_wr_i && (reg_addr_i == ADDR_PTR)) begin
         ptr_reg <= reg_wdata_i[6:0];
      end else if (wr_coef) begin
         ptr_reg <= ptr_reg + 7'h01;
      end
   end

   // coefficient banks; contents undefined until loaded
   always_ff @(posedge clk_sys_i) begin
      if (wr_coef) begin
         coef_mem[reg_addr_i[0]][ptr_reg] <= reg_wdata_i;
      end
   end

   // status read; non-status reads return zero
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= stat_rd ? stat_vec : 8'h00;
      end
   end

   // reserved status bits always read zero
   assign stat_vec[3] = 1'b0;
   assign stat_vec[7] = 1'b0;

   // ----------------------------------------------------------------
   // per-channel logic
   // ----------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      chan_state_t st_reg, st_next;
      logic dig_en, ana_en, clamp, bank;
      logic [4:0] drop;
      logic [15:0] buf_data, sel_sample;
      logic buf_valid, pop, active, starve, und_evt, ovf_evt, sat;
      logic got_reg, und_reg, ovf_reg;
      logic [6:0] clr_reg;

      // this channel's fields of the shared registers
      assign dig_en = ctrl_reg[c*CTRL_STRIDE + DIG_EN_B];
      assign ana_en = ctrl_reg[c*CTRL_STRIDE + ANA_EN_B];
      assign bank = ctrl_reg[c*CTRL_STRIDE + COEF_SEL_B];
      assign drop = ctrl_reg[c*CTRL_STRIDE + BITSEL_LSB +: 5];
      assign clamp = gain_reg[c*GAIN_STRIDE + CLAMP_B];

      // samples are consumed only while running or draining
      assign active = (st_reg == ST_RUN) || (st_reg == ST_DRAIN);
      assign pop = input_sample_tick_i[c] && active && buf_valid;
      assign starve = input_sample_tick_i[c] && active && !buf_valid;

      // before any word and with the port off, zeros are not underrun
      assign und_evt = starve && (got_reg || tx_port_en_i);
      assign ovf_evt = filter_sample_tick_i[c] && active &&
         !bypass_o && sat;

      // enable, drain and clear sequencing
      always_comb begin
         st_next = st_reg;
         case (st_reg)
            ST_IDLE: if (dig_en) st_next = ST_RUN;
            ST_RUN: if (!dig_en) st_next = ST_DRAIN;
            // a starved tick means the buffered words are used up
            ST_DRAIN: if (starve) st_next = ST_CLEAR;
            ST_CLEAR: begin
               if (clr_reg == 7'(CLEAR_CYCLES - 1)) begin
                  st_next = ST_IDLE;
               end
            end
            default: st_next = ST_IDLE;
         endcase
      end

      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            st_reg <= ST_IDLE;
            chan_active_o[c] <= 1'b0;
         end else begin
            st_reg <= st_next;
            chan_active_o[c] <= (st_next == ST_RUN) ||
               (st_next == ST_DRAIN);
         end
      end

      // data sample clear walk: one address per cycle
      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            clr_reg <= 7'h00;
            data_clear_o[c] <= 1'b0;
            data_clear_addr_o[c] <= 7'h00;
         end else begin
            clr_reg <= (st_reg == ST_CLEAR) ? clr_reg + 7'h01 : 7'h00;
            data_clear_o[c] <= (st_next == ST_CLEAR);
            data_clear_addr_o[c] <= (st_next == ST_CLEAR &&
               st_reg == ST_CLEAR) ? clr_reg + 7'h01 : 7'h00;
         end
      end

      // two-word buffer; requests stop as soon as the drain starts
      // a word taken at the edge that starts the drain is still kept
      tx_word_buffer #(
         .W(16),
         .DEPTH(BUF_DEPTH)
      ) u_buf (
         .clk_sys_i(clk_sys_i),
         .rst_i(rst_i),
         .in_data_i(word_i[c]),
         .in_valid_i(word_valid_i[c]),
         .in_en_i(st_next == ST_RUN),
         .in_ready_o(word_ready_o[c]),
         .out_data_o(buf_data),
         .out_valid_o(buf_valid),
         .out_ready_i(pop)
      );

      // sample feed: fresh word, else zero default, else repeat last
      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            fir_in_o[c] <= 16'h0000;
            fir_in_valid_o[c] <= 1'b0;
            got_reg <= 1'b0;
         end else begin
            fir_in_valid_o[c] <= input_sample_tick_i[c] && active;
            if (st_reg == ST_IDLE && dig_en) begin
               fir_in_o[c] <= 16'h0000;
               got_reg <= 1'b0;
            end else if (pop) begin
               fir_in_o[c] <= buf_data;
               got_reg <= 1'b1;
            end
            // when starved the held word is sent again
            // (zeros before the first word, as nothing else is held)
         end
      end

      tx_bit_selector #(
         .AW(ACC_W),
         .OW(SAMPLE_W)
      ) u_sel (
         .acc_i(acc_i[c]),
         .drop_i(drop),
         .sample_o(sel_sample),
         .sat_o(sat)
      );

      // second-stage input: selector result, or raw words in bypass
      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            stage2_o[c] <= 16'h0000;
            stage2_valid_o[c] <= 1'b0;
         end else if (bypass_o) begin
            stage2_valid_o[c] <= fir_in_valid_o[c];
            if (fir_in_valid_o[c]) stage2_o[c] <= fir_in_o[c];
         end else begin
            stage2_valid_o[c] <= filter_sample_tick_i[c] && active;
            if (filter_sample_tick_i[c] && active) begin
               stage2_o[c] <= sel_sample;
            end
         end
      end

      // sticky flags: a set in the read cycle survives the read
      // a control write never clears them; only a status read does
      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            und_reg <= 1'b0;
            ovf_reg <= 1'b0;
         end else begin
            und_reg <= und_evt || (und_reg && !stat_rd);
            ovf_reg <= ovf_evt || (ovf_reg && !stat_rd);
         end
      end

      // flags per channel: A in low nibble, B in high nibble
      assign stat_vec[c*STAT_STRIDE + IDLE_B] = (st_reg == ST_IDLE);
      assign stat_vec[c*STAT_STRIDE + UNDER_B] = und_reg;
      assign stat_vec[c*STAT_STRIDE + OVF_B] = ovf_reg;

      // coefficient read for the filter from the chosen bank
      // a bank switch while running takes effect on the next read
      always_ff @(posedge clk_sys_i) begin
         coef_o[c] <= coef_mem[bank][coef_rd_addr_i[c]];
      end

      // analogue stage codes, one cycle behind the registers
      // clamp only matters while the analogue stage is off
      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            analog_en_o[c] <= 1'b0;
            gain_o[c] <= 6'h00;
            mute_o[c] <= 1'b0;
            mid_rail_o[c] <= 1'b0;
            out_hiz_o[c] <= 1'b1;
         end else begin
            analog_en_o[c] <= ana_en;
            gain_o[c] <= gain_reg[c*GAIN_STRIDE + GAIN_LSB +: 6];
            mute_o[c] <= (gain_reg[c*GAIN_STRIDE + GAIN_LSB +: 6] ==
               MUTE_CODE);
            mid_rail_o[c] <= !ana_en && clamp;
            out_hiz_o[c] <= !ana_en && !clamp;
         end
      end
   end
endmodule // tx_channel_control
`default_nettype wire

// >>> core/tx_word_buffer.sv
/*
 * Small word buffer with valid/ready on both sides.
 * Ready and valid are registered; in_en_i is the filler's wish to
 * accept words in the next cycle, from logic on the same clock.
 */
`default_nettype none
module tx_word_buffer #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // filling side
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   input wire logic in_en_i,
   output logic in_ready_o,
   // draining side
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("buffer depth must be a power of two, at least 2");
   end
   logic [W-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg, rd_reg;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic push, pop;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_reg[rd_reg];
   assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
   // storage
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end
   // pointers, fill level and handshake flags
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         wr_reg <= wr_reg + PW'(push);
         rd_reg <= rd_reg + PW'(pop);
         cnt_reg <= cnt_next;
         // ready looks ahead so a full buffer never takes a word
         in_ready_o <= in_en_i && (cnt_next < CW'(DEPTH));
         out_valid_o <= (cnt_next != '0);
      end
   end
endmodule // tx_word_buffer
`default_nettype wire
